// ==== hdc_regs.sv ====
`timescale 1ns/1ns
`include "hdc_defines.svh"
module hdc_regs (
    input  wire logic            clk,            // 20 MHz host clock
    input  wire logic            nrst,           // sync reset, active low
    input  wire logic            ce,             // clock enable, freezes state
    input  wire logic [7:0]      cmd_code,       // processor command code
    input  wire logic            cmd_valid,      // command strobe, one cycle
    input  wire logic [15:0]     wr_data,        // write data from processor
    output logic [15:0]          rd_data,        // registered read data
    input  wire logic            irq_src,        // enabled sources, from irq block
    input  wire logic            dma_ack_pin,    // ack pin, asynchronous
    input  wire logic            end_xfer_pin,   // external end-of-transfer pin
    input  wire logic            cnt_done,       // internal byte counter reached
    input  wire logic            cnt_nonzero,    // transfer counter loaded nonzero
    input  wire logic            word_done,      // one bus cycle of dma done
    output logic                 host_irq_pin,   // interrupt pin, polarity applied
    output logic                 host_dma_req_out, // dma request, polarity applied
    output logic                 dma_ack_active, // ack seen, qualifies strobes
    output logic                 end_xfer,       // end of transfer pulse
    output hdc_pkg::hdc_cfg_s    cfg             // configuration fan-out
);
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // burst length decode; reserved code falls back to single cycle
    function automatic logic [3:0] burst_len(input logic [1:0] f);
        case (f)
            `HDC_BURST_FOUR:  burst_len = `HDC_BURST_CNT4;
            `HDC_BURST_EIGHT: burst_len = `HDC_BURST_CNT8;
            default:          burst_len = `HDC_BURST_CNT1;
        endcase
    endfunction : burst_len

    // ---------------------------------------------------------------
    // command decode
    // ---------------------------------------------------------------
    // one command per enabled cycle; codes owned by neighbouring
    // blocks (transfer counter, status) fall through untouched, so
    // this bank never answers for a register it does not hold
    hdc_pkg::hdc_cmd_s cmd;                       // decoded strobes
    assign cmd.hw_rd  = ce && cmd_valid && cmd_code == `HDC_CMD_HW_RD;
    assign cmd.hw_wr  = ce && cmd_valid && cmd_code == `HDC_CMD_HW_WR;
    assign cmd.dma_rd = ce && cmd_valid && cmd_code == `HDC_CMD_DMA_RD;
    assign cmd.dma_wr = ce && cmd_valid && cmd_code == `HDC_CMD_DMA_WR;

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [15:0] hw_q,  hw_d;                     // hardware configuration
    logic [15:0] dma_q, dma_d;                    // dma configuration
    logic [15:0] rd_q,  rd_d;                     // read data hold
    logic        xfer_done;                       // completion event
    logic        eot_s1_q, eot_s2_q, eot_s3_q;    // eot synchroniser + edge
    logic        ack_s1_q, ack_s2_q;              // ack synchroniser
    logic        irq_prev_q;                      // for edge detection
    logic        irq_pulse_q;                     // edge mode pulse

    // masks keep reserved bits zero and bus width fixed at 01;
    // forcing the field here is cheaper than rejecting bad writes,
    // and software reading back always sees the only legal width
    assign hw_d = cmd.hw_wr
                ? ((wr_data & 16'(`HDC_HW_WMASK))
                   | {11'h000, `HDC_BUS_WIDTH_16, 3'b000})
                : hw_q;
    // go bit cleared on completion; a write in the same cycle wins over the completion
    always_comb begin
        dma_d = dma_q;
        if (cmd.dma_wr) begin
            dma_d = wr_data & 16'(`HDC_DMA_WMASK);
        end
        if (xfer_done && !cmd.dma_wr) begin
            dma_d[`HDC_BIT_GO] = 1'b0;
        end
    end
    assign rd_d = cmd.hw_rd  ? hw_q
                : cmd.dma_rd ? dma_q
                : rd_q;

    // ---------------------------------------------------------------
    // register update process
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            hw_q  <= `HDC_HW_RESET;
            dma_q <= `HDC_DMA_RESET;
            rd_q  <= 16'h0000;
        end else if (ce) begin
            hw_q  <= hw_d;
            dma_q <= dma_d;
            rd_q  <= rd_d;
        end
    end
    assign rd_data = rd_q;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    // first stage read only by the second, edge detector on stage two
    always_ff @(posedge clk) begin
        if (!nrst) begin
            // idle pin is high at the reset polarity (active low), so the
            // chain starts at that level and no false edge follows reset
            eot_s1_q <= 1'b1;
            eot_s2_q <= 1'b1;
            eot_s3_q <= 1'b1;
            ack_s1_q <= 1'b1;
            ack_s2_q <= 1'b1;
        end else if (ce) begin
            eot_s1_q <= end_xfer_pin;
            eot_s2_q <= eot_s1_q;
            eot_s3_q <= eot_s2_q;
            ack_s1_q <= dma_ack_pin;
            ack_s2_q <= ack_s1_q;
        end
    end

    // ---------------------------------------------------------------
    // dma control
    // ---------------------------------------------------------------
    wire eot_lvl  = eot_s2_q ~^ hw_q[`HDC_BIT_EOT_POL];
    wire eot_prev = eot_s3_q ~^ hw_q[`HDC_BIT_EOT_POL];
    wire eot_edge = ce && eot_lvl && !eot_prev;
    // ack polarity only supports active low; reserved 1 ignored
    assign dma_ack_active = !ack_s2_q && !hw_q[`HDC_BIT_ACK_MODE];
    // counter mode ends only on counter, else only on external eot
    assign end_xfer  = dma_q[`HDC_BIT_USE_CNT] ? (ce && cnt_done) : eot_edge;
    assign xfer_done = end_xfer && dma_q[`HDC_BIT_GO];
    wire   req_raw   = dma_q[`HDC_BIT_GO]
                     && (!dma_q[`HDC_BIT_USE_CNT] || cnt_nonzero);
    // polarity bit 1 drives the request as is, 0 drives it inverted;
    // word_done is a hook for the burst engine and is not used here
    assign host_dma_req_out = req_raw ~^ hw_q[`HDC_BIT_REQ_POL];

    assign cfg.pulldown_internal_sel  = hw_q[`HDC_BIT_PULLDOWN];
    assign cfg.keep_clk_in_suspend    = hw_q[`HDC_BIT_KEEP_CLK];
    assign cfg.onchip_overcurrent_sel = hw_q[`HDC_BIT_OC_SEL];
    assign cfg.use_byte_counter       = dma_q[`HDC_BIT_USE_CNT];
    assign cfg.list_buffer_sel        = dma_q[`HDC_BIT_LIST_SEL];
    assign cfg.xfer_direction         = dma_q[`HDC_BIT_DIR];
    assign cfg.burst_cycles = burst_len(dma_q[`HDC_BURST_LO +: 2]);

    // ---------------------------------------------------------------
    // interrupt pin
    // ---------------------------------------------------------------
    // the source mask lives outside; only the master gate is applied
    // here, before any edge detection, so a disabled pin never leaves
    // a stale edge behind to fire when the gate opens again
    wire irq_gated = irq_src && hw_q[`HDC_BIT_IRQ_EN];
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_prev_q  <= 1'b0;
            irq_pulse_q <= 1'b0;
        end else if (ce) begin
            irq_prev_q  <= irq_gated;
            irq_pulse_q <= irq_gated && !irq_prev_q;
        end
    end
    // edge mode gives one-cycle pulse, level mode follows source
    wire irq_act = hw_q[`HDC_BIT_IRQ_EDGE] ? irq_pulse_q : irq_prev_q;
    assign host_irq_pin = irq_act ~^ hw_q[`HDC_BIT_IRQ_POL];

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // all checks run on the host clock and stay quiet during reset;
    // a low clock enable freezes every register, so a check that
    // wants a fresh sample carries ce in its antecedent, and the
    // others except chk_irq_gate_off hold equally well across a freeze

    // ---------------------------------------------------------------
    // interrupt pin
    // ---------------------------------------------------------------
    // enable low for two samples leaves nothing in flight, so the
    // internal active level must be gone by then
    chk_irq_gate_off: assert property (@(posedge clk) disable iff (!nrst)
        !hw_q[`HDC_BIT_IRQ_EN] && !$past(hw_q[`HDC_BIT_IRQ_EN]) |-> !irq_act)
        else $error("interrupt active while master enable off");

    // an idle pin rests at the inverse of its programmed active level;
    // a wrong idle level would look like a stuck interrupt to the host
    chk_irq_pin_idle: assert property (@(posedge clk) disable iff (!nrst)
        !irq_act |-> host_irq_pin == !hw_q[`HDC_BIT_IRQ_POL])
        else $error("interrupt pin not at inactive level");

    // edge mode gives exactly one cycle per rising source; a longer
    // pulse could be counted twice by an edge-sensitive controller
    chk_edge_pulse_one: assert property (@(posedge clk) disable iff (!nrst)
        ce && irq_pulse_q |=> !irq_pulse_q)
        else $error("edge pulse longer than one cycle");

    // ---------------------------------------------------------------
    // register access
    // ---------------------------------------------------------------
    // the width field reads 01 whatever software wrote
    // into it, from reset onwards
    chk_bus_width_fixed: assert property (@(posedge clk) disable iff (!nrst)
        hw_q[4:3] == `HDC_BUS_WIDTH_16)
        else $error("bus width field not 01");

    // a hardware write stores the writable bits and forces the
    // width field, nothing more
    chk_hw_write_data: assert property (@(posedge clk) disable iff (!nrst)
        cmd.hw_wr |=> hw_q == (($past(wr_data) & 16'(`HDC_HW_WMASK)) | 16'h0008))
        else $error("hardware config write mismatch");

    // read data for the hardware register is the value held
    // in the cycle of the command
    chk_hw_read_data: assert property (@(posedge clk) disable iff (!nrst)
        cmd.hw_rd |=> rd_data == $past(hw_q))
        else $error("hardware config read mismatch");

    // a dma write stores only its writable bits; the write also
    // wins against a completion falling in the same cycle
    chk_dma_write_data: assert property (@(posedge clk) disable iff (!nrst)
        cmd.dma_wr |=> dma_q == ($past(wr_data) & 16'(`HDC_DMA_WMASK)))
        else $error("dma config write mismatch");

    // read data for the dma register is the value held in the
    // cycle of the command
    chk_dma_read_data: assert property (@(posedge clk) disable iff (!nrst)
        cmd.dma_rd |=> rd_data == $past(dma_q))
        else $error("dma config read mismatch");

    // read data stands until the next read command, so a slow
    // processor may pick it up late
    chk_rd_hold: assert property (@(posedge clk) disable iff (!nrst)
        !cmd.hw_rd && !cmd.dma_rd |=> $stable(rd_data))
        else $error("read data changed without a read");

    // reserved positions never hold a one; software sees
    // zero there whatever it wrote
    chk_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
        (hw_q & 16'hE200) == 16'h0000 && (dma_q & 16'hFF88) == 16'h0000)
        else $error("reserved bit stored");

    // the longest burst decodes to eight cycles for the
    // burst engine
    chk_burst_decode: assert property (@(posedge clk) disable iff (!nrst)
        dma_q[6:5] == `HDC_BURST_EIGHT |-> cfg.burst_cycles == `HDC_BURST_CNT8)
        else $error("burst eight decode wrong");

    // ---------------------------------------------------------------
    // dma control
    // ---------------------------------------------------------------
    // completion drops the go bit one edge later unless
    // software rewrites the register in that cycle
    chk_go_self_clear: assert property (@(posedge clk) disable iff (!nrst)
        xfer_done && !cmd.dma_wr |=> !dma_q[`HDC_BIT_GO])
        else $error("go bit not cleared on completion");

    // only a write can start a transfer; hardware never
    // sets the go bit by itself
    chk_go_needs_write: assert property (@(posedge clk) disable iff (!nrst)
        !dma_q[`HDC_BIT_GO] && !cmd.dma_wr |=> !dma_q[`HDC_BIT_GO])
        else $error("go bit set without a write");

    // counter mode holds the request back until a non-zero
    // count has been loaded
    chk_req_needs_count: assert property (@(posedge clk) disable iff (!nrst)
        dma_q[`HDC_BIT_USE_CNT] && !cnt_nonzero |-> !req_raw)
        else $error("request raised with zero count");

    // counter mode ignores the external end pin; only the
    // counter may end the transfer
    chk_end_cnt_only: assert property (@(posedge clk) disable iff (!nrst)
        dma_q[`HDC_BIT_USE_CNT] && !cnt_done |-> !end_xfer)
        else $error("transfer ended without counter in counter mode");

    // the request pin follows the internal request at the
    // programmed polarity
    chk_req_polarity: assert property (@(posedge clk) disable iff (!nrst)
        host_dma_req_out == (hw_q[`HDC_BIT_REQ_POL] ? req_raw : !req_raw))
        else $error("request pin at wrong polarity");

    // ---------------------------------------------------------------
    // coverage of the main scenarios
    // ---------------------------------------------------------------
    // configuration written by the processor
    cov_hw_write: cover property (@(posedge clk) disable iff (!nrst) cmd.hw_wr);
    // a transfer ran to completion
    cov_dma_done: cover property (@(posedge clk) disable iff (!nrst) xfer_done);
    // an edge-mode interrupt pulse went out
    cov_irq_edge: cover property (@(posedge clk) disable iff (!nrst)
        irq_pulse_q && hw_q[`HDC_BIT_IRQ_EDGE]);
    // a transfer ended by the external end pin
    cov_eot_end: cover property (@(posedge clk) disable iff (!nrst)
        end_xfer && !dma_q[`HDC_BIT_USE_CNT]);
    // a transfer ended by the byte counter
    cov_cnt_end: cover property (@(posedge clk) disable iff (!nrst)
        end_xfer && dma_q[`HDC_BIT_USE_CNT]);
endmodule : hdc_regs

// ==== hdc_defines.svh ====
`ifndef HDC_DEFINES_SVH
`define HDC_DEFINES_SVH

// ---------------------------------------------------------------
// command codes
// ---------------------------------------------------------------
`define HDC_CMD_HW_RD      8'h20
`define HDC_CMD_HW_WR      8'hA0
`define HDC_CMD_DMA_RD     8'h21
`define HDC_CMD_DMA_WR     8'hA1

// ---------------------------------------------------------------
// hardware configuration fields
// ---------------------------------------------------------------
`define HDC_HW_RESET       16'h0028
`define HDC_HW_WMASK       16'h1DE7
`define HDC_BIT_IRQ_EN     0
`define HDC_BIT_IRQ_EDGE   1
`define HDC_BIT_IRQ_POL    2
`define HDC_BIT_REQ_POL    5
`define HDC_BIT_ACK_POL    6
`define HDC_BIT_EOT_POL    7
`define HDC_BIT_ACK_MODE   8
`define HDC_BIT_OC_SEL     10
`define HDC_BIT_KEEP_CLK   11
`define HDC_BIT_PULLDOWN   12
`define HDC_BUS_WIDTH_16   2'b01

// ---------------------------------------------------------------
// dma configuration fields
// ---------------------------------------------------------------
`define HDC_DMA_RESET      16'h0000
`define HDC_DMA_WMASK      16'h0077
`define HDC_BIT_DIR        0
`define HDC_BIT_LIST_SEL   1
`define HDC_BIT_USE_CNT    2
`define HDC_BIT_GO         4
`define HDC_BURST_LO       5
`define HDC_BURST_SINGLE   2'b00
`define HDC_BURST_FOUR     2'b01
`define HDC_BURST_EIGHT    2'b10
`define HDC_BURST_CNT1     4'h1
`define HDC_BURST_CNT4     4'h4
`define HDC_BURST_CNT8     4'h8

`endif

// ==== hdc_pkg.sv ====
package hdc_pkg;
    // decoded processor command
    typedef struct packed {
        logic hw_rd;
        logic hw_wr;
        logic dma_rd;
        logic dma_wr;
    } hdc_cmd_s;

    // configuration fan-out to the host core
    typedef struct packed {
        logic       pulldown_internal_sel;
        logic       keep_clk_in_suspend;
        logic       onchip_overcurrent_sel;
        logic       use_byte_counter;
        logic       list_buffer_sel;
        logic       xfer_direction;
        logic [3:0] burst_cycles;
    } hdc_cfg_s;
endpackage : hdc_pkg

// ==== hdc_dma_host.sv ====
`timescale 1ns/1ns
// ---------------------------------------------
// processor-side dma partner
// ---------------------------------------------
module hdc_dma_host #(
    parameter int EOT_AFTER = 4       // acked cycles before end pin fires
) (
    input  wire logic clk,            // host clock
    input  wire logic req_act,        // request seen, polarity removed
    input  wire logic slow,           // stall before the first acknowledge of each request
    output logic      dma_ack_pin,    // acknowledge, active low
    output logic      end_xfer_pin    // end of transfer, active low
);
    int n_ack;                        // acknowledged cycles this episode
    int n_wait;                       // cycles waited on the request
    initial begin
        dma_ack_pin = 1'b1;
        end_xfer_pin = 1'b1;
        n_ack = 0;
        n_wait = 0;
    end
    // answer a held request; released pins sit at their pulled-up level
    always @(posedge clk) begin
        if (req_act) begin
            n_wait <= n_wait + 1;
            if (n_wait >= (slow ? 3 : 0)) begin
                dma_ack_pin <= 1'b0;
                n_ack <= n_ack + 1;
            end
        end else begin
            dma_ack_pin <= 1'b1;
            n_wait <= 0;
            n_ack <= 0;
        end
        end_xfer_pin <= (n_ack != EOT_AFTER);
    end
endmodule : hdc_dma_host

// ==== host_dma_irq_config_regs_tb.sv ====
`timescale 1ns/1ns
module host_dma_irq_config_regs_tb;
    // ---------------------------------------------
    // stimulus signals and bookkeeping
    // ---------------------------------------------
    logic clk = 0, nrst = 0, ce = 1, cmd_valid = 0, irq_src = 0;
    logic cnt_done = 0, cnt_nonzero = 0, word_done = 0, slow = 0;
    logic [7:0] cmd_code = 0;
    logic [15:0] wr_data = 0, rd_data, d;
    logic host_irq_pin, host_dma_req_out, dma_ack_active, end_xfer;
    logic dma_ack_pin, end_xfer_pin, rd_pend = 0, eot_seen = 0, req_act;
    hdc_pkg::hdc_cfg_s cfg;
    logic [15:0] q[$];                // expected read words, oldest first
    int err_total = 0, compares = 0, cyc = 0, seed = 29902, i;
    // request polarity stays at its reset value (active high) until the random test writes it
    assign req_act = (host_dma_req_out === 1'b1);
    initial forever #25 clk = ~clk;
    hdc_regs dut (.clk(clk), .nrst(nrst), .ce(ce), .cmd_code(cmd_code),
        .cmd_valid(cmd_valid), .wr_data(wr_data), .rd_data(rd_data),
        .irq_src(irq_src), .dma_ack_pin(dma_ack_pin), .end_xfer_pin(end_xfer_pin),
        .cnt_done(cnt_done), .cnt_nonzero(cnt_nonzero), .word_done(word_done),
        .host_irq_pin(host_irq_pin), .host_dma_req_out(host_dma_req_out),
        .dma_ack_active(dma_ack_active), .end_xfer(end_xfer), .cfg(cfg));
    hdc_dma_host #(.EOT_AFTER(4)) host (.clk(clk), .req_act(req_act), .slow(slow),
        .dma_ack_pin(dma_ack_pin), .end_xfer_pin(end_xfer_pin));
    // ---------------------------------------------
    // tasks and monitors
    // ---------------------------------------------
    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk16
    task automatic chk1(input logic g, input logic e);
        chk16({15'h0, g}, {15'h0, e});
    endtask : chk1
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    // one command cycle, driven off the sampling edge
    task automatic cmd(input logic [7:0] c, input logic [15:0] w);
        @(negedge clk);
        cmd_code = c;
        wr_data = w;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask : cmd
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        q.push_back(e);
        cmd(c, 16'h0000);
    endtask : rd
    task automatic results;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results
    // read word lands one edge after the command edge
    always @(posedge clk) rd_pend <= nrst && cmd_valid && (cmd_code == 8'h20 || cmd_code == 8'h21);
    always @(negedge clk) if (rd_pend) chk16(rd_data, q.pop_front());
    always @(posedge clk) if (end_xfer === 1'b1) eot_seen <= 1'b1;
    // hang guard, well beyond the expected hundred or so cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            results();
        end
    end
    initial begin
        tick(3);
        nrst = 1'b1;
        rd(8'h20, 16'h0028);
        rd(8'h21, 16'h0000);
        $display("test reset done");
        cmd(8'hA1, 16'h0010);
        tick(3);
        chk1(dma_ack_active, 1'b1);
        for (i = 0; i < 40 && req_act; i++) tick(1);
        chk1(eot_seen, 1'b1);
        rd(8'h21, 16'h0000);
        $display("test eot done");
        cmd(8'hA1, 16'h0014);
        tick(2);
        chk1(host_dma_req_out, 1'b0);
        cmd(8'hA1, 16'h0000);
        tick(2);
        slow = 1'b1;
        cnt_nonzero = 1'b1;
        cmd(8'hA1, 16'h0014);
        tick(20);
        rd(8'h21, 16'h0014);
        cnt_done = 1'b1;
        tick(1);
        cnt_done = 1'b0;
        tick(4);
        rd(8'h21, 16'h0004);
        $display("test counter done");
        irq_src = 1'b1;
        cmd(8'hA0, 16'h0028);
        tick(3);
        chk1(host_irq_pin, 1'b1);
        cmd(8'hA0, 16'h0029);
        tick(3);
        chk1(host_irq_pin, 1'b0);
        cmd(8'hA0, 16'h002D);
        tick(3);
        chk1(host_irq_pin, 1'b1);
        cmd(8'hA0, 16'h002F);
        irq_src = 1'b0;
        tick(3);
        irq_src = 1'b1;
        tick(1);
        chk1(host_irq_pin, 1'b1);
        tick(4);
        chk1(host_irq_pin, 1'b0);
        irq_src = 1'b0;
        $display("test irq done");
        for (i = 0; i < 3; i++) begin
            d = $random(seed) & 16'hFEFF;
            cmd(8'hA0, d);
            cmd(8'hA2, ~d);
            rd(8'h20, (d & 16'h1DE7) | 16'h0008);
            chk1(cfg.pulldown_internal_sel, d[12]);
            chk1(cfg.keep_clk_in_suspend, d[11]);
            chk1(cfg.onchip_overcurrent_sel, d[10]);
            d = ($random(seed) & 16'hFF8F) | (16'(i) << 5);
            cmd(8'hA1, d);
            rd(8'h21, d & 16'h0077);
            chk16({12'h000, cfg.burst_cycles}, (i == 0) ? 16'h0001 : 16'h0004 * i);
            chk1(cfg.xfer_direction, d[0]);
            chk1(cfg.list_buffer_sel, d[1]);
            chk1(cfg.use_byte_counter, d[2]);
        end
        $display("test random done");
        tick(2);
        results();
    end
endmodule : host_dma_irq_config_regs_tb
